// [hdl/csi_out_pkg.sv]
// constants shared by the csi output configuration block and its fifo
package csi_out_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0]  IDX_LANE_POWER     = 8'h6A;
   localparam logic [7:0]  IDX_FORMAT_POL     = 8'h6B;
   localparam logic [7:0]  IDX_INDIRECT_INDEX = 8'h6C;
   localparam logic [7:0]  IDX_INDIRECT_DATA  = 8'h6D;
   localparam int          ADDR_W             = 12;
   localparam logic [7:0]  RST_LANE_POWER     = 8'h00;
   localparam logic [7:0]  RST_FORMAT_POL     = 8'h00;
   localparam logic [7:0]  RST_INDIRECT_INDEX = 8'h00;
   localparam logic [7:0]  RST_INDIRECT_DATA  = 8'h00;
   // lane power control fields
   localparam int          LANE_COUNT_LSB     = 4;
   localparam int          DATA_SLEEP_BIT     = 3;
   localparam int          CLOCK_SLEEP_BIT    = 2;
   localparam int          ALWAYS_ON_BIT      = 1;
   localparam int          SOFT_DISABLE_BIT   = 0;
   localparam logic [7:0]  LANE_POWER_MASK    = 8'h3F;
   // format and polarity fields
   localparam int          OUT_FMT_LSB        = 4;
   localparam int          IN_FMT_LSB         = 2;
   localparam int          VS_INV_BIT         = 1;
   localparam int          DE_INV_BIT         = 0;
   // lane count codes
   localparam logic [1:0]  LANES_FOUR_A       = 2'h0;
   localparam logic [1:0]  LANES_FOUR_B       = 2'h1;
   localparam logic [1:0]  LANES_TWO          = 2'h2;
   localparam logic [1:0]  LANES_ONE          = 2'h3;
   // low-power line levels {p,n}
   localparam logic [1:0]  LP11               = 2'h3;
   localparam logic [1:0]  LP10               = 2'h2;
   localparam logic [1:0]  LP01               = 2'h1;
   localparam logic [1:0]  LP00               = 2'h0;
   localparam int          ENTRY_STEPS        = 4;
   // timing
   localparam int          CLK_PERIOD_NS      = 40;
   localparam int          TLPX_NS            = 50;
   localparam int          TLPX_CYC           = (TLPX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          TWAKEUP_US         = 1000;
   localparam int          TWAKEUP_CYC        = TWAKEUP_US * 1000 / CLK_PERIOD_NS;
   localparam int          PIX_W              = 24;
   localparam int          FIFO_DEPTH         = 16;
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;

   typedef enum logic [2:0] {
      ST_OFF   = 3'h0,
      ST_IDLE  = 3'h1,
      ST_HS    = 3'h2,
      ST_ENTRY = 3'h3,
      ST_SLEEP = 3'h4,
      ST_EXIT  = 3'h5
   } lane_state_t;
endpackage : csi_out_pkg

// [hdl/pixel_fifo.sv]
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module pixel_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wptr;
   logic [AW:0]      rptr;
   logic             full;
   logic             empty;

   assign full      = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
   assign empty     = (wptr == rptr);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rptr[AW-1:0]];

   always_ff @(posedge aclk) begin
      if (in_valid && !full) begin
         mem[wptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wptr <= '0;
      end else if (in_valid && !full) begin
         wptr <= wptr + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rptr <= '0;
      end else if (out_ready && !empty) begin
         rptr <= rptr + 1'b1;
      end
   end
endmodule : pixel_fifo

// [hdl/csi_output_config.sv]
// csi output configuration: register file, link sampling, lane power sequencing
`timescale 1ns/10ps
module csi_output_config
   import csi_out_pkg::*;
#(
   parameter int WAKE_CYC = csi_out_pkg::TWAKEUP_CYC
) (
   // clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // axi4-lite slave
   input  wire logic [csi_out_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [csi_out_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // link receiver video, asynchronous to aclk
   input  wire logic                         link_clk,
   input  wire logic                         link_vsync,
   input  wire logic                         link_de,
   input  wire logic [csi_out_pkg::PIX_W-1:0] link_pixel,
   // pixel stream toward the csi packer
   output logic [csi_out_pkg::PIX_W-1:0]     pix_data,
   output logic                              pix_valid,
   input  wire logic                         pix_ready,
   output logic                              pix_frame_active,
   output logic                              pix_line_active,
   // lane control
   output logic [3:0]                        lane_enable,
   output logic [1:0]                        data_lane_lp,
   output logic                              data_lane_hs,
   output logic [1:0]                        clock_lane_lp,
   output logic                              clock_lane_hs,
   output logic [3:0]                        output_format,
   output logic [1:0]                        input_format
);
   import csi_out_pkg::*;

   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[9:2];
   endfunction : reg_index

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = reg_index(a);
      addr_mapped = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0)
                    && (i >= IDX_LANE_POWER) && (i <= IDX_INDIRECT_DATA);
   endfunction : addr_mapped

   logic [7:0]  csi_lane_power_control;
   logic [7:0]  csi_format_polarity;
   logic [7:0]  csi_indirect_index;
   logic [7:0]  indirect_mem [256];

   logic        data_lanes_sleep;
   logic        clock_lane_sleep;
   logic        clock_lane_always_on;
   logic        output_soft_disable;
   logic        vsync_invert;
   logic        data_enable_invert;

   assign data_lanes_sleep     = csi_lane_power_control[DATA_SLEEP_BIT];
   assign clock_lane_sleep     = csi_lane_power_control[CLOCK_SLEEP_BIT];
   assign clock_lane_always_on = csi_lane_power_control[ALWAYS_ON_BIT];
   assign output_soft_disable  = csi_lane_power_control[SOFT_DISABLE_BIT];
   assign vsync_invert         = csi_format_polarity[VS_INV_BIT];
   assign data_enable_invert   = csi_format_polarity[DE_INV_BIT];

   // ---------------- axi4-lite write path
   logic                aw_held;
   logic                w_held;
   logic [ADDR_W-1:0]   aw_addr;
   logic [7:0]          w_byte;
   logic                w_lane0;
   logic                do_write;
   logic [7:0]          wr_idx;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx        = reg_index(aw_addr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held  <= 1'b1;
         w_byte  <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_en;
   assign wr_en = do_write && w_lane0 && addr_mapped(aw_addr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         csi_lane_power_control <= RST_LANE_POWER;
         csi_format_polarity    <= RST_FORMAT_POL;
         csi_indirect_index     <= RST_INDIRECT_INDEX;
      end else if (wr_en) begin
         unique case (wr_idx)
            IDX_LANE_POWER:     csi_lane_power_control <= w_byte;
            IDX_FORMAT_POL:     csi_format_polarity    <= w_byte;
            IDX_INDIRECT_INDEX: csi_indirect_index     <= w_byte;
            default: ;
         endcase
      end
   end

   // internal registers behind the index/data port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 256; i++) begin
            indirect_mem[i] <= RST_INDIRECT_DATA;
         end
      end else if (wr_en && wr_idx == IDX_INDIRECT_DATA) begin
         indirect_mem[csi_indirect_index] <= w_byte;
      end
   end

   // ---------------- axi4-lite read path
   logic [7:0] rd_byte;
   logic [7:0] rd_idx;
   assign rd_idx = reg_index(s_axi_araddr);
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_byte = 8'h00;
      unique case (rd_idx)
         IDX_LANE_POWER:     rd_byte = csi_lane_power_control;
         IDX_FORMAT_POL:     rd_byte = csi_format_polarity;
         IDX_INDIRECT_INDEX: rd_byte = csi_indirect_index;
         IDX_INDIRECT_DATA:  rd_byte = indirect_mem[csi_indirect_index];
         default:            rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= addr_mapped(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h0000_0000;
         s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- link sampling: two flops, then edge detect
   logic [PIX_W+2:0] link_meta;
   logic [PIX_W+2:0] link_sync;
   logic             link_clk_prev;
   logic             link_rise;
   logic             vs_active;
   logic             de_active;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_meta     <= '0;
         link_sync     <= '0;
         link_clk_prev <= 1'b0;
      end else begin
         link_meta     <= {link_clk, link_vsync, link_de, link_pixel};
         link_sync     <= link_meta;
         link_clk_prev <= link_sync[PIX_W+2];
      end
   end

   assign link_rise = link_sync[PIX_W+2] && !link_clk_prev;
   assign vs_active = link_sync[PIX_W+1] ^ vsync_invert;
   assign de_active = link_sync[PIX_W] ^ data_enable_invert;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pix_frame_active <= 1'b0;
         pix_line_active  <= 1'b0;
      end else if (link_rise) begin
         pix_frame_active <= vs_active;
         pix_line_active  <= de_active;
      end
   end

   // ---------------- pixel fifo; soft disable flushes it
   logic fifo_rstn;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fill;
   lane_state_t lane_state;
   assign fifo_rstn = aresetn && !output_soft_disable;
   assign fill      = link_rise && de_active && vs_active;

   pixel_fifo #(
      .WIDTH (PIX_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (fifo_rstn),
      .in_valid  (fill),
      .in_ready  (fifo_in_ready),
      .in_data   (link_sync[PIX_W-1:0]),
      .out_valid (fifo_out_valid),
      .out_ready (pix_ready && lane_state == ST_HS),
      .out_data  (pix_data)
   );
   assign pix_valid = fifo_out_valid && (lane_state == ST_HS);

   // ---------------- lane power state machine
   logic [15:0] step_cnt;
   logic [2:0]  entry_step;
   logic        step_done;
   assign step_done = (step_cnt == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn || output_soft_disable) begin
         lane_state <= ST_OFF;
         step_cnt   <= 16'(TLPX_CYC - 1);
         entry_step <= 3'h0;
      end else begin
         step_cnt <= step_done ? 16'h0000 : step_cnt - 16'h0001;
         unique case (lane_state)
            ST_OFF: begin
               lane_state <= ST_IDLE;
               step_cnt   <= 16'(TLPX_CYC - 1);
            end
            ST_IDLE: begin
               if (data_lanes_sleep) begin
                  lane_state <= ST_ENTRY;
                  entry_step <= 3'h0;
                  step_cnt   <= 16'(TLPX_CYC - 1);
               end else if (step_done) begin
                  lane_state <= ST_HS;
               end
            end
            ST_HS: begin
               if (data_lanes_sleep) begin
                  lane_state <= ST_ENTRY;
                  entry_step <= 3'h0;
                  step_cnt   <= 16'(TLPX_CYC - 1);
               end
            end
            ST_ENTRY: begin
               if (step_done) begin
                  step_cnt <= 16'(TLPX_CYC - 1);
                  if (entry_step == 3'(ENTRY_STEPS - 1)) begin
                     lane_state <= ST_SLEEP;
                  end else begin
                     entry_step <= entry_step + 3'h1;
                  end
               end
            end
            ST_SLEEP: begin
               if (!data_lanes_sleep) begin
                  lane_state <= ST_EXIT;
                  step_cnt   <= 16'(WAKE_CYC - 1);
               end
            end
            ST_EXIT: begin
               if (step_done) begin
                  lane_state <= ST_IDLE;
                  step_cnt   <= 16'(TLPX_CYC - 1);
               end
            end
            default: lane_state <= ST_OFF;
         endcase
      end
   end

   // line levels: entry walks LP11, LP10, LP00, LP01 then rests at LP00
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_lane_lp  <= LP11;
         clock_lane_lp <= LP11;
         data_lane_hs  <= 1'b0;
         clock_lane_hs <= 1'b0;
      end else begin
         unique case (lane_state)
            ST_ENTRY: begin
               unique case (entry_step)
                  3'h0:    data_lane_lp <= LP11;
                  3'h1:    data_lane_lp <= LP10;
                  3'h2:    data_lane_lp <= LP00;
                  default: data_lane_lp <= LP01;
               endcase
            end
            ST_SLEEP: data_lane_lp <= LP00;
            ST_EXIT:  data_lane_lp <= LP10;
            default:  data_lane_lp <= LP11;
         endcase
         clock_lane_lp <= (lane_state == ST_SLEEP && clock_lane_sleep) ? LP00 : LP11;
         data_lane_hs  <= (lane_state == ST_HS) && pix_line_active;
         clock_lane_hs <= (lane_state == ST_HS)
                          && (clock_lane_always_on || (pix_frame_active && pix_line_active));
      end
   end

   // ---------------- format and lane-count outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lane_enable   <= 4'hF;
         output_format <= 4'h0;
         input_format  <= 2'h0;
      end else begin
         unique case (csi_lane_power_control[LANE_COUNT_LSB +: 2])
            LANES_FOUR_A, LANES_FOUR_B: lane_enable <= 4'hF;
            LANES_TWO:                  lane_enable <= 4'h3;
            LANES_ONE:                  lane_enable <= 4'h1;
         endcase
         output_format <= csi_format_polarity[OUT_FMT_LSB +: 4];
         input_format  <= csi_format_polarity[IN_FMT_LSB +: 2];
      end
   end

   // ---------------- assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_lane_count;
      csi_lane_power_control[5:4] == LANES_TWO |=> lane_enable == 4'h3;
   endproperty
   a_lane_count: assert property (p_lane_count) else $error("lane enable mismatch");

   property p_sleep_lp00;
      lane_state == ST_SLEEP |=> data_lane_lp == LP00;
   endproperty
   a_sleep_lp00: assert property (p_sleep_lp00) else $error("sleep not LP00");

   property p_clock_sleep_gate;
      !data_lanes_sleep && lane_state != ST_SLEEP |=> clock_lane_lp == LP11;
   endproperty
   a_clock_sleep_gate: assert property (p_clock_sleep_gate)
      else $error("clock lane slept alone");

   property p_always_on;
      lane_state == ST_HS && clock_lane_always_on && !output_soft_disable |=> clock_lane_hs;
   endproperty
   a_always_on: assert property (p_always_on) else $error("clock left hs");

   property p_soft_disable;
      output_soft_disable |=> lane_state == ST_OFF && !pix_valid;
   endproperty
   a_soft_disable: assert property (p_soft_disable) else $error("disable ignored");

   property p_out_format;
      ##1 output_format == $past(csi_format_polarity[7:4]);
   endproperty
   a_out_format: assert property (p_out_format) else $error("format lag");

   property p_vs_invert;
      link_rise |=> pix_frame_active == ($past(link_sync[PIX_W+1]) ^ $past(vsync_invert));
   endproperty
   a_vs_invert: assert property (p_vs_invert) else $error("vsync polarity");

   property p_de_invert;
      link_rise |=> pix_line_active == ($past(link_sync[PIX_W]) ^ $past(data_enable_invert));
   endproperty
   a_de_invert: assert property (p_de_invert) else $error("de polarity");

   sequence s_exit_start;
      lane_state == ST_SLEEP && !data_lanes_sleep && !output_soft_disable;
   endsequence
   property p_exit_seq;
      s_exit_start |=> lane_state == ST_EXIT ##1 data_lane_lp == LP10;
   endproperty
   a_exit_seq: assert property (p_exit_seq) else $error("no exit sequence");

   property p_indirect_write;
      wr_en && wr_idx == IDX_INDIRECT_DATA
         |=> indirect_mem[$past(csi_indirect_index)] == $past(w_byte);
   endproperty
   a_indirect_write: assert property (p_indirect_write) else $error("data port write");
endmodule : csi_output_config

// [test/csi_sink.sv]
// receiver model on the pixel stream: stalls on request, else takes every other cycle
`timescale 1ns/10ps
module csi_sink
   import csi_out_pkg::*;
(
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // pixel stream
   input  wire logic [PIX_W-1:0] pix_data,
   input  wire logic             pix_valid,
   output logic                  pix_ready,
   // control and tally
   input  wire logic             stall,
   output int                    n_rx,
   output logic [PIX_W-1:0]      last_rx
);
   logic pace;
   assign pix_ready = !stall && pace;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pace <= 1'b0;
         n_rx <= 0;
         last_rx <= '0;
      end else begin
         pace <= !pace;
         if (pix_valid && pix_ready) begin
            n_rx <= n_rx + 1;
            last_rx <= pix_data;
         end
      end
   end
endmodule : csi_sink

// [test/csi_output_config_bench.sv]
// bench for the csi output configuration block
`timescale 1ns/10ps
module csi_output_config_bench;
   import csi_out_pkg::*;
   logic              aclk = 0, aresetn = 0, link_clk = 0, link_vsync = 0, link_de = 0;
   logic              stall = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic              s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid, pix_valid, pix_ready;
   logic              pix_frame_active, pix_line_active, data_lane_hs, clock_lane_hs;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rdat;
   logic [3:0]        s_axi_wstrb = 4'hF, lane_enable, output_format;
   logic [1:0]        s_axi_bresp, s_axi_rresp, data_lane_lp, clock_lane_lp, input_format, resp;
   logic [PIX_W-1:0]  link_pixel = '0, pix_data, last_rx;
   int                n_rx, n0, n_errors = 0, n_compared = 0;
   always #20 aclk = ~aclk;
   csi_output_config #(.WAKE_CYC(20)) dut (.*);
   csi_sink sink (.*);
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [7:0] d);
      logic pa, pw, ta, tw;
      pa = 1;
      pw = 1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rd
   // link clock runs only inside a frame, 320 ns period
   task frame(input int n, input logic act);
      @(posedge aclk);
      link_vsync <= act;
      link_de <= act;
      for (int k = 0; k < n; k++) begin
         link_pixel <= 24'hA50000 + k;
         repeat (4) @(posedge aclk);
         link_clk <= 1'b1;
         repeat (4) @(posedge aclk);
         link_clk <= 1'b0;
      end
      link_vsync <= !act;
      link_de <= !act;
      repeat (30) @(posedge aclk);
   endtask : frame
   task t_regs;
      for (int i = 0; i < 4; i++) begin
         rd(12'h1A8 + 4 * i);
         chk("reset value", rdat, 0);
      end
      rd(12'h1B8);
      chk("unmapped read", {rdat[29:0], resp}, {30'h0, RESP_SLVERR});
      wr(12'h1A8, 8'hC0);
      chk("write resp", resp, RESP_OKAY);
      rd(12'h1A8);
      chk("lane power rw", rdat, 32'hC0);
      wr(12'h1B0, 8'h12);
      wr(12'h1B4, 8'h5A);
      wr(12'h1B0, 8'h34);
      wr(12'h1B4, 8'hC3);
      wr(12'h1B0, 8'h12);
      rd(12'h1B4);
      chk("indirect 12", rdat, 32'h5A);
      wr(12'h1B0, 8'h34);
      rd(12'h1B4);
      chk("indirect 34", rdat, 32'hC3);
      wr(12'h1B0, 8'hFF);
      rd(12'h1B0);
      chk("index parked", rdat, 32'hFF);
      // a write without the low byte lane must leave the register alone
      s_axi_wstrb <= 4'hE;
      wr(12'h1B0, 8'h77);
      s_axi_wstrb <= 4'hF;
      rd(12'h1B0);
      chk("masked write", rdat, 32'hFF);
      wr(12'h1B8, 8'h55);
      chk("unmapped write", resp, RESP_SLVERR);
   endtask : t_regs
   task t_fields;
      for (int c = 0; c < 4; c++) begin
         wr(12'h1A8, c << 4);
         repeat (2) @(posedge aclk);
         chk("lane_enable", lane_enable, (c == 2) ? 4'h3 : (c == 3) ? 4'h1 : 4'hF);
      end
      for (int f = 0; f < 10; f++) begin
         wr(12'h1AC, {f[3:0], f[1:0], 2'b00});
         repeat (2) @(posedge aclk);
         chk("output_format", output_format, f);
         chk("input_format", input_format, f % 4);
      end
      wr(12'h1AC, 8'h00);
   endtask : t_fields
   task t_video;
      n0 = n_rx;
      frame(4, 1'b1);
      chk("pixels", n_rx - n0, 4);
      chk("last pixel", last_rx, 24'hA50003);
      frame(2, 1'b0);
      chk("low pixels no invert", n_rx - n0, 4);
      wr(12'h1AC, 8'h03);
      frame(3, 1'b0);
      chk("low pixels inverted", n_rx - n0, 7);
      chk("frame active", pix_frame_active, 1);
      chk("line active", pix_line_active, 1);
      wr(12'h1AC, 8'h00);
      stall <= 1'b1;
      n0 = n_rx;
      frame(20, 1'b1);
      chk("full fifo valid", pix_valid, 1);
      stall <= 1'b0;
      repeat (60) @(posedge aclk);
      chk("drained words", n_rx - n0, FIFO_DEPTH);
      chk("empty valid", pix_valid, 0);
      stall <= 1'b1;
      n0 = n_rx;
      frame(4, 1'b1);
      wr(12'h1A8, 8'h01);
      repeat (2) @(posedge aclk);
      chk("disabled valid", pix_valid, 0);
      wr(12'h1A8, 8'h00);
      stall <= 1'b0;
      repeat (30) @(posedge aclk);
      chk("flushed words", n_rx - n0, 0);
   endtask : t_video
   task t_sleep;
      wr(12'h1A8, 8'h04);
      repeat (20) @(posedge aclk);
      chk("clock lp alone", {clock_lane_lp, data_lane_lp}, {LP11, LP11});
      wr(12'h1A8, 8'h0C);
      repeat (20) @(posedge aclk);
      chk("data lp sleep", data_lane_lp, LP00);
      chk("clock lp sleep", clock_lane_lp, LP00);
      wr(12'h1A8, 8'h02);
      repeat (10) @(posedge aclk);
      chk("exit lp", data_lane_lp, LP10);
      chk("exit clock hs", clock_lane_hs, 0);
      repeat (40) @(posedge aclk);
      chk("always on hs", clock_lane_hs, 1);
      chk("active data hs", data_lane_hs, 1);
      wr(12'h1A8, 8'h00);
      // one blanking pixel so the block sees the frame and line end
      frame(1, 1'b0);
      chk("gated hs", clock_lane_hs, 0);
      chk("blank data hs", data_lane_hs, 0);
   endtask : t_sleep
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   initial begin
      #500us;
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_fields();
      t_video();
      t_sleep();
      end_of_test();
   end
endmodule : csi_output_config_bench
